// ==== hw/analog_voter.sv ====
// Redundant analog input voter for one group of input modules
// Summary of operation
// [RULE1] Only two- or three-member groups vote; other sizes pass inputs unvoted.
// [RULE2] With three inputs, each channel's result is the median value.
// [RULE3] Channel n result goes to voted output word n.
// [RULE4] Each module's raw channel value stays readable beside the vote.
// [RULE5] Inputs with discrepancy or module fault are excluded from the vote.
// [RULE6] Degrade per group: three, two, one, or three, two, default.
// [RULE7] Inputs deviating from the median (mean of inputs 0 and 1 in two-member groups) beyond the percentage limit are flagged.
// [RULE8] Discrepancy is reported only after persisting the filter time.
// [RULE9] Non-redundant channels bypass voting and pass module 0's input through.
// [RULE10] No autotest is applied to analog groups.
// [RULE11] Two valid inputs give their mean; one valid input passes directly.
module analog_voter #(
	parameter int NUM_CH = voter_pkg::NUM_CH,
	parameter int DATA_W = voter_pkg::DATA_W,
	parameter int TICK_CYCLES = voter_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire voter_pkg::group_cfg_t cfg,
	input wire logic [voter_pkg::NUM_IN-1:0][NUM_CH-1:0][DATA_W-1:0] inValue,
	input wire logic [voter_pkg::NUM_IN-1:0] moduleFault,
	output voter_pkg::vote_res_t [NUM_CH-1:0] voted,
	output logic [voter_pkg::NUM_IN-1:0][NUM_CH-1:0][DATA_W-1:0] rawValue,
	output logic [voter_pkg::NUM_IN-1:0][NUM_CH-1:0] discrepant,
	output logic groupVoted
);
	localparam int NI = voter_pkg::NUM_IN;

	typedef struct packed {
		voter_pkg::vote_res_t [NUM_CH-1:0] voted;
		logic [NI-1:0][NUM_CH-1:0][DATA_W-1:0] raw;
		logic groupVoted;
	} state_t;

	logic [1:0] rstSync;
	logic rst_n;
	logic tick;
	logic [NI-1:0][NUM_CH-1:0] rawDisc;
	logic [NI-1:0][NUM_CH-1:0] filtDisc;
	state_t s;
	state_t next_s;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rst_n = rstSync[1];

	function automatic logic signed [DATA_W-1:0] median3(
		input logic signed [DATA_W-1:0] a,
		input logic signed [DATA_W-1:0] b,
		input logic signed [DATA_W-1:0] c);
		logic signed [DATA_W-1:0] lo;
		logic signed [DATA_W-1:0] hi;
		lo = (a < b) ? a : b;
		hi = (a < b) ? b : a;
		if (c < lo) begin
			median3 = lo;
		end else if (c > hi) begin
			median3 = hi;
		end else begin
			median3 = c;
		end
	endfunction

	// Floor of the mean; one extra bit keeps the sum from wrapping
	function automatic logic signed [DATA_W-1:0] mean2(
		input logic signed [DATA_W-1:0] a,
		input logic signed [DATA_W-1:0] b);
		logic signed [DATA_W:0] sum;
		sum = {a[DATA_W-1], a} + {b[DATA_W-1], b};
		mean2 = sum[DATA_W:1];
	endfunction

	// True when |x - ref| * 100 exceeds |ref| * limit
	function automatic logic deviates(
		input logic signed [DATA_W-1:0] x,
		input logic signed [DATA_W-1:0] ref_v,
		input logic [voter_pkg::PCT_W-1:0] pct);
		logic signed [DATA_W+1:0] diff;
		logic [DATA_W+1:0] adiff;
		logic [DATA_W+1:0] aref;
		logic [DATA_W+15:0] lhs;
		logic [DATA_W+15:0] rhs;
		diff = (DATA_W+2)'(x) - (DATA_W+2)'(ref_v);
		adiff = diff[DATA_W+1] ? (DATA_W+2)'(-diff) : diff;
		aref = ref_v[DATA_W-1] ? (DATA_W+2)'(-(DATA_W+2)'(ref_v))
			: (DATA_W+2)'(ref_v);
		lhs = (DATA_W+16)'(adiff) * (DATA_W+16)'(voter_pkg::PCT_FULL);
		rhs = (DATA_W+16)'(aref) * (DATA_W+16)'(pct);
		deviates = lhs > rhs;
	endfunction

	// Analog groups get no autotest: the block has no stimulus path at all
	// RULE10
	tick_divider #(
		.CYCLES(TICK_CYCLES)
	) divider (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	logic isVoting;
	assign isVoting = (cfg.members == voter_pkg::CNT_TWO) ||
		(cfg.members == voter_pkg::CNT_THREE); // RULE1

	// Reference for discrepancy checks is the median of all three inputs, or the mean of inputs 0 and 1 below three members
	logic signed [NUM_CH-1:0][DATA_W-1:0] refValue;

	genvar gc;
	genvar gi;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
			always_comb begin
				if (cfg.members == voter_pkg::CNT_THREE) begin
					refValue[gc] = median3(inValue[0][gc], inValue[1][gc],
						inValue[2][gc]);
				end else begin
					refValue[gc] = mean2(inValue[0][gc], inValue[1][gc]);
				end
			end
			for (gi = 0; gi < NI; gi++) begin : g_in
				always_comb begin
					rawDisc[gi][gc] = isVoting && !cfg.nonRedundant[gc] &&
						(gi < int'(cfg.members)) &&
						deviates(inValue[gi][gc], refValue[gc],
						cfg.limitPct); // RULE7
				end
				discrepancy_filter #(
					.FILT_W(voter_pkg::FILT_W)
				) filt (
					.clk(clk),
					.rst_n(rst_n),
					.tick(tick),
					.raw(rawDisc[gi][gc]),
					.filterMs(cfg.filterMs),
					.flagged(filtDisc[gi][gc])
				);
			end
		end
	endgenerate

	always_comb begin
		logic [NI-1:0] ok;
		logic [1:0] cnt;
		logic signed [DATA_W-1:0] v0;
		logic signed [DATA_W-1:0] v1;
		ok = '0;
		cnt = voter_pkg::CNT_ZERO;
		v0 = '0;
		v1 = '0;
		next_s = s;
		next_s.raw = inValue; // RULE4
		next_s.groupVoted = isVoting;
		for (int c = 0; c < NUM_CH; c++) begin
			for (int i = 0; i < NI; i++) begin
				ok[i] = (i < int'(cfg.members)) && !moduleFault[i] &&
					!filtDisc[i][c]; // RULE5
			end
			cnt = 2'(ok[0]) + 2'(ok[1]) + 2'(ok[2]);
			// Lowest-numbered valid inputs feed the mean and the single pass
			v0 = ok[0] ? inValue[0][c] : (ok[1] ? inValue[1][c]
				: inValue[2][c]);
			v1 = ok[2] ? inValue[2][c] : inValue[1][c];
			next_s.voted[c].used = ok;
			if (!isVoting || cfg.nonRedundant[c]) begin
				// Unvoted channels pass the first module's value through
				next_s.voted[c].value = inValue[0][c]; // RULE9
				next_s.voted[c].mode = voter_pkg::VOTE_NONE; // RULE1
				next_s.voted[c].used = '0;
			end else if (cnt == voter_pkg::CNT_THREE) begin
				next_s.voted[c].value = median3(inValue[0][c],
					inValue[1][c], inValue[2][c]); // RULE2
				next_s.voted[c].mode = voter_pkg::VOTE_MEDIAN;
			end else if (cnt == voter_pkg::CNT_TWO) begin
				next_s.voted[c].value = mean2(v0, v1); // RULE11
				next_s.voted[c].mode = voter_pkg::VOTE_MEAN;
			end else if (cnt == voter_pkg::CNT_ONE &&
				cfg.degrade == voter_pkg::DEG_TO_ONE) begin
				next_s.voted[c].value = v0; // RULE6 RULE11
				next_s.voted[c].mode = voter_pkg::VOTE_SINGLE;
			end else begin
				next_s.voted[c].value = cfg.defaultValue; // RULE6
				next_s.voted[c].mode = voter_pkg::VOTE_NONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign voted = s.voted; // RULE3
	assign rawValue = s.raw;
	assign discrepant = filtDisc;
	assign groupVoted = s.groupVoted;

	median_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
		(isVoting && !cfg.nonRedundant[0] && moduleFault == '0 &&
		filtDisc[2:0] == '0 && cfg.members == voter_pkg::CNT_THREE)
		|=> voted[0].value == median3($past(inValue[0][0]),
		$past(inValue[1][0]), $past(inValue[2][0])))
		else $error("median not selected"); // RULE2
	group_size_a: assert property (@(posedge clk) disable iff (!rst_n)
		!isVoting |=> voted[0].mode == voter_pkg::VOTE_NONE && !groupVoted)
		else $error("odd group size was voted"); // RULE1
	raw_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> rawValue == $past(inValue))
		else $error("raw value not kept"); // RULE4
	fault_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
		moduleFault[1] |=> !voted[0].used[1])
		else $error("faulty input used in vote"); // RULE5
	default_val_a: assert property (@(posedge clk) disable iff (!rst_n)
		(isVoting && !cfg.nonRedundant[0] && moduleFault == 3'h7 &&
		cfg.degrade == voter_pkg::DEG_TO_DEFAULT)
		|=> voted[0].value == $past(cfg.defaultValue))
		else $error("default value not applied"); // RULE6
	bypass_ch_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg.nonRedundant[1] |=> voted[1].value == $past(inValue[0][1]))
		else $error("non-redundant channel was voted"); // RULE9
	mean_two_a: assert property (@(posedge clk) disable iff (!rst_n)
		(isVoting && !cfg.nonRedundant[0] && moduleFault == 3'h4 &&
		cfg.members == voter_pkg::CNT_THREE && filtDisc[1:0] == '0)
		|=> voted[0].value == mean2($past(inValue[0][0]),
		$past(inValue[1][0])))
		else $error("two-input mean wrong"); // RULE11
	disc_check_a: assert property (@(posedge clk) disable iff (!rst_n)
		rawDisc[0][0] |-> isVoting && !cfg.nonRedundant[0])
		else $error("discrepancy on unvoted channel"); // RULE7
	// Degradation steps are checked on channel 0; the word map on all
	disc_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
		filtDisc[2][0] |=> !voted[0].used[2])
		else $error("discrepant input used in vote"); // RULE5
	member_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg.members == voter_pkg::CNT_TWO |=> !voted[0].used[2])
		else $error("input beyond group size used"); // RULE1
	group_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		isVoting |=> groupVoted)
		else $error("voting group not reported"); // RULE1
	median_used_a: assert property (@(posedge clk) disable iff (!rst_n)
		voted[0].mode == voter_pkg::VOTE_MEDIAN |-> voted[0].used == '1)
		else $error("median formed without all inputs"); // RULE2
	single_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
		(isVoting && !cfg.nonRedundant[0] && moduleFault == 3'h3 &&
		cfg.members == voter_pkg::CNT_THREE && !filtDisc[2][0] &&
		cfg.degrade == voter_pkg::DEG_TO_ONE)
		|=> voted[0].value == $past(inValue[2][0]) &&
		voted[0].mode == voter_pkg::VOTE_SINGLE)
		else $error("single remaining input not passed"); // RULE6
	default_two_a: assert property (@(posedge clk) disable iff (!rst_n)
		(isVoting && !cfg.nonRedundant[0] && moduleFault == 3'h6 &&
		cfg.members == voter_pkg::CNT_THREE &&
		cfg.degrade == voter_pkg::DEG_TO_DEFAULT)
		|=> voted[0].value == $past(cfg.defaultValue))
		else $error("default not applied below two inputs"); // RULE6
	mean_members_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!cfg.nonRedundant[0] && moduleFault == '0 &&
		cfg.members == voter_pkg::CNT_TWO && filtDisc[1:0] == '0)
		|=> voted[0].value == mean2($past(inValue[0][0]),
		$past(inValue[1][0])) && voted[0].mode == voter_pkg::VOTE_MEAN)
		else $error("two-member mean wrong"); // RULE11
	disc_unvoted_a: assert property (@(posedge clk) disable iff (!rst_n)
		!isVoting |=> discrepant == '0)
		else $error("discrepancy flagged in unvoted group"); // RULE1
	bypass_used_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg.nonRedundant[2] |=> voted[2].used == '0 &&
		voted[2].mode == voter_pkg::VOTE_NONE)
		else $error("non-redundant channel marked as voted"); // RULE9

	// Word map and unvoted pass-through hold for every channel
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_chk
			word_map_a: assert property (@(posedge clk) disable iff (!rst_n)
				(!cfg.nonRedundant[gc] && moduleFault == '0 &&
				filtDisc == '0 && cfg.members == voter_pkg::CNT_THREE)
				|=> voted[gc].value == median3($past(inValue[0][gc]),
				$past(inValue[1][gc]), $past(inValue[2][gc])))
				else $error("channel result in wrong word"); // RULE3
			pass_word_a: assert property (@(posedge clk) disable iff (!rst_n)
				!isVoting |=> voted[gc].value == $past(inValue[0][gc]) &&
				voted[gc].used == '0)
				else $error("unvoted channel not passed through"); // RULE1
		end
	endgenerate

	median_cov: cover property (@(posedge clk) disable iff (!rst_n)
		voted[0].mode == voter_pkg::VOTE_MEDIAN);
	mean_cov: cover property (@(posedge clk) disable iff (!rst_n)
		voted[0].mode == voter_pkg::VOTE_MEAN);
	single_cov: cover property (@(posedge clk) disable iff (!rst_n)
		voted[0].mode == voter_pkg::VOTE_SINGLE);
	disc_cov: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(discrepant[0][0]));
	default_cov: cover property (@(posedge clk) disable iff (!rst_n)
		voted[0].mode == voter_pkg::VOTE_NONE && groupVoted);
endmodule // analog_voter

// ==== hw/discrepancy_filter.sv ====
// Persistence filter for one input's discrepancy condition
module discrepancy_filter #(
	parameter int FILT_W = voter_pkg::FILT_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic raw,
	input wire logic [FILT_W-1:0] filterMs,
	output logic flagged
);
	typedef struct packed {
		logic [FILT_W-1:0] elapsed;
		logic flagged;
	} state_t;
	state_t s;
	state_t next_s;

	always_comb begin
		next_s = s;
		if (!raw) begin
			// Any gap in the condition restarts the wait
			next_s.elapsed = '0;
			next_s.flagged = 1'b0;
		end else if (s.elapsed >= filterMs) begin
			next_s.flagged = 1'b1; // RULE8
		end else if (tick) begin
			next_s.elapsed = s.elapsed + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign flagged = s.flagged;

	filter_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(flagged) |-> $past(raw) && $past(s.elapsed) >= $past(filterMs))
		else $error("flag raised before filter time elapsed"); // RULE8
	filter_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
		!raw |=> !flagged)
		else $error("flag kept after condition cleared"); // RULE8
endmodule // discrepancy_filter

// ==== hw/tick_divider.sv ====
// Millisecond enable pulse for the discrepancy filters
module tick_divider #(
	parameter int CYCLES = voter_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);
	typedef struct packed {
		logic [31:0] count;
		logic tick;
	} state_t;
	state_t s;
	state_t next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.count == 32'(CYCLES - 1)) begin
			next_s.count = 32'h0;
			next_s.tick = 1'b1;
		end else begin
			next_s.count = s.count + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

	tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
		tick |-> ##1 !tick)
		else $error("tick lasted more than one cycle");
endmodule // tick_divider

// ==== hw/voter_pkg.sv ====
// Shared types and constants of the redundant analog input voter
package voter_pkg;
	localparam int DATA_W = 16;
	localparam int NUM_CH = 4;
	localparam int NUM_IN = 3;
	localparam int PCT_W = 7;
	localparam int FILT_W = 16;
	// Filter time unit is one millisecond at the 25 MHz clock
	localparam int CLK_HZ = 25000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int PCT_FULL = 100;
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_TWO = 2'h2;
	localparam logic [1:0] CNT_THREE = 2'h3;

	typedef enum logic [1:0] {
		DEG_TO_ONE = 2'h0,
		DEG_TO_DEFAULT = 2'h1
	} degrade_t;

	typedef enum logic [1:0] {
		VOTE_NONE = 2'h0,
		VOTE_SINGLE = 2'h1,
		VOTE_MEAN = 2'h2,
		VOTE_MEDIAN = 2'h3
	} vote_mode_t;

	// Per-group configuration set by the application side
	typedef struct packed {
		logic [1:0] members;
		degrade_t degrade;
		logic [PCT_W-1:0] limitPct;
		logic [FILT_W-1:0] filterMs;
		logic signed [DATA_W-1:0] defaultValue;
		logic [NUM_CH-1:0] nonRedundant;
	} group_cfg_t;

	// Result of one channel
	typedef struct packed {
		logic signed [DATA_W-1:0] value;
		vote_mode_t mode;
		logic [NUM_IN-1:0] used;
	} vote_res_t;
endpackage : voter_pkg

// ==== testbench/analog_source.sv ====
// Behavioural model of the redundant analog input modules
module analog_source (
	input wire logic clk,
	input wire logic [2:0][3:0][15:0] target,
	input wire logic [2:0] faultSet,
	output logic [2:0][3:0][15:0] inValue,
	output logic [2:0] moduleFault
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		inValue = '0;
		moduleFault = '0;
	end
	// Each module reports once per scan, one cycle behind its sensor
	always @(posedge clk) begin
		inValue <= target;
		moduleFault <= faultSet;
	end
endmodule // analog_source

// ==== testbench/tb_top.sv ====
// Self-checking bench of the analog voter
`define CHECK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic arst_n = 0;
	voter_pkg::group_cfg_t cfg, stageCfg;
	logic [2:0][3:0][15:0] target, stage, inValue, rawValue;
	logic [2:0] faultSet, moduleFault;
	voter_pkg::vote_res_t [3:0] voted;
	logic [2:0][3:0] discrepant;
	logic groupVoted;
	int fails = 0;
	int tests_run = 0;
	voter_pkg::vote_res_t expQ[$];
	bit fullQ[$];
	event chk;
	always #20 clk = ~clk;
	analog_source i_src (.clk(clk), .target(target), .faultSet(faultSet),
		.inValue(inValue), .moduleFault(moduleFault));
	analog_voter #(.TICK_CYCLES(4)) i_dut (.clk(clk), .arst_n(arst_n),
		.cfg(cfg), .inValue(inValue), .moduleFault(moduleFault),
		.voted(voted), .rawValue(rawValue), .discrepant(discrepant),
		.groupVoted(groupVoted));
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apply(input logic [2:0] f);
		@(posedge clk);
		target <= stage;
		faultSet <= f;
		cfg <= stageCfg;
		repeat (3) @(posedge clk);
		#1;
		`CHECK("raw", stage, rawValue)
	endtask
	// Expected vote worked out independently of the design
	task automatic expect_all(input logic [2:0] excl);
		logic [2:0] u;
		logic signed [15:0] v[3];
		logic signed [16:0] s;
		logic signed [15:0] tmp;
		voter_pkg::vote_res_t e;
		int n;
		bit full;
		for (int c = 0; c < 4; c++) begin
			full = 1;
			n = 0;
			u = ~(faultSet | excl) & (cfg.members == 2'h2 ? 3'h3 : 3'h7);
			for (int i = 0; i < 3; i++)
				if (u[i]) begin
					v[n] = target[i][c];
					n++;
				end
			e = '{target[0][c], voter_pkg::VOTE_NONE, 3'h0};
			if (cfg.members inside {2'h2, 2'h3} && !cfg.nonRedundant[c]) begin
				e.used = u;
				if (n == 3) begin
					e.mode = voter_pkg::VOTE_MEDIAN;
					for (int p = 0; p < 2; p++)
						for (int q = 0; q < 2 - p; q++)
							if (v[q] > v[q+1]) begin
								tmp = v[q];
								v[q] = v[q+1];
								v[q+1] = tmp;
							end
					e.value = v[1];
				end else if (n == 2) begin
					s = 17'(v[0]) + 17'(v[1]);
					e = '{s[16:1], voter_pkg::VOTE_MEAN, u};
				end else if (n == 1 && cfg.degrade == voter_pkg::DEG_TO_ONE) begin
					e = '{v[0], voter_pkg::VOTE_SINGLE, u};
				end else begin
					e.value = cfg.defaultValue;
					full = 0;
				end
			end
			expQ.push_back(e);
			fullQ.push_back(full);
		end
		->chk;
	endtask
	always @(chk) begin
		voter_pkg::vote_res_t e;
		for (int c = 0; c < 4; c++) begin
			e = expQ.pop_front();
			`CHECK("value", e.value, voted[c].value)
			if (fullQ.pop_front()) begin
				`CHECK("mode", e.mode, voted[c].mode)
				`CHECK("used", e.used, voted[c].used)
			end
		end
	end
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
	initial begin
		logic [2:0] flist[11];
		stageCfg = '{2'h3, voter_pkg::DEG_TO_ONE, 7'h7F, 16'h0002, 16'h1234,
			4'h0};
		cfg = stageCfg;
		stage = '0;
		target = '0;
		faultSet = '0;
		flist = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h6, 3'h5, 3'h7, 3'h3, 3'h5,
			3'h6, 3'h7};
		void'($urandom(32'h851B5354));
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 11; k++) begin
			for (int i = 0; i < 3; i++)
				for (int c = 0; c < 4; c++)
					stage[i][c] = 16'(500 + $urandom_range(500));
			if (k == 7)
				stageCfg.degrade = voter_pkg::DEG_TO_DEFAULT;
			apply(3'h0);
			expect_all(3'h0);
			apply(flist[k]);
			expect_all(3'h0);
		end
		$display("Test median and degrade done");
		for (int m = 0; m < 4; m++) begin
			stageCfg.members = 2'(m);
			stageCfg.nonRedundant = (m == 3) ? 4'h5 : 4'h0;
			apply(3'h0);
			expect_all(3'h0);
			`CHECK("groupVoted", 1'(m >= 2), groupVoted)
		end
		$display("Test membership and bypass done");
		stageCfg.nonRedundant = 4'h0;
		stageCfg.limitPct = 7'h0A;
		stage = {{4{16'h0BB8}}, {8{16'h03E8}}};
		apply(3'h0);
		`CHECK("early flag", 12'h0, discrepant)
		expect_all(3'h0);
		repeat (20) @(posedge clk);
		#1;
		`CHECK("late flag", 12'hF00, discrepant)
		expect_all(3'h4);
		stage[2] = '{4{16'h03E8}};
		apply(3'h0);
		`CHECK("cleared flag", 12'h0, discrepant)
		expect_all(3'h0);
		$display("Test discrepancy done");
		@(posedge clk);
		end_of_test();
	end
endmodule // tb_top
